// *** verif/pcd_port2_bank_assertions.sv ***
// Concurrent checks on the ports of the port 2 register bank.
`timescale 1ns/1ps
module pcd_port2_bank_chk (
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic srst_i,
  // Watched ports.
  input wire logic reg_we_i,
  input wire logic mii_we_i,
  input wire logic [1:0] egress_queue_mode_i,
  input wire logic [pcd_pkg::RATE_W-1:0] egress_limit_p2_o,
  input wire logic [pcd_pkg::RATE_W-1:0] egress_limit_p3_o,
  input wire logic egress_limit_p2_en_o,
  input wire logic egress_limit_p3_en_o,
  input wire logic cdt_start_o,
  input wire logic an_restart_o,
  input wire logic an_failed_i,
  input wire logic an_speed_100_i,
  input wire logic link_detect_i,
  input wire logic link_pass_o,
  input wire logic speed_100_o,
  input wire logic full_duplex_o,
  input wire pcd_pkg::pcd_line_ctrl_type line_ctrl_o
);
  import pcd_pkg::*;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);
  property p_p3_en;
    egress_limit_p3_en_o == (egress_queue_mode_i == QUEUES_FOUR && egress_limit_p3_o != 7'h00);
  endproperty
  a_p3_en: assert property (p_p3_en) else $error("priority 3 limit enable wrong");
  property p_p2_en;
    egress_limit_p2_en_o == (egress_queue_mode_i == QUEUES_FOUR && egress_limit_p2_o != 7'h00);
  endproperty
  a_p2_en: assert property (p_p2_en) else $error("priority 2 limit enable wrong");
  property p_start;
    cdt_start_o |-> ($past(reg_we_i) || $past(mii_we_i)) ##1 !cdt_start_o;
  endproperty
  a_start: assert property (p_start) else $error("cable test start pulse wrong");
  property p_restart;
    an_restart_o |-> ($past(reg_we_i) || $past(mii_we_i)) ##1 !an_restart_o;
  endproperty
  a_restart: assert property (p_restart) else $error("restart pulse wrong");
  property p_link;
    link_pass_o == (line_ctrl_o.force_link || link_detect_i);
  endproperty
  a_link: assert property (p_link) else $error("link pass wrong");
  property p_speed;
    speed_100_o == (line_ctrl_o.an_enable ? an_speed_100_i : line_ctrl_o.speed_100);
  endproperty
  a_speed: assert property (p_speed) else $error("speed select wrong");
  property p_half;
    line_ctrl_o.an_enable && an_failed_i |-> !full_duplex_o;
  endproperty
  a_half: assert property (p_half) else $error("failed negotiation not half duplex");
  property p_mdix;
    line_ctrl_o.force_mdix |-> !line_ctrl_o.auto_mdix_en;
  endproperty
  a_mdix: assert property (p_mdix) else $error("forced crossover while automatic");
  c_start: cover property (cdt_start_o);
  c_restart: cover property (an_restart_o);
  c_p3: cover property (egress_limit_p3_en_o);
endmodule // pcd_port2_bank_chk
bind pcd_port2_bank pcd_port2_bank_chk chk_u (.mclk_i, .srst_i, .reg_we_i, .mii_we_i,
  .egress_queue_mode_i, .egress_limit_p2_o, .egress_limit_p3_o, .egress_limit_p2_en_o,
  .egress_limit_p3_en_o, .cdt_start_o, .an_restart_o, .an_failed_i, .an_speed_100_i,
  .link_detect_i, .link_pass_o, .speed_100_o, .full_duplex_o, .line_ctrl_o);

// *** verif/pcd_port2_bank_tb.sv ***
// Self-checking bench for the port 2 register bank.
`timescale 1ns/1ps
module pcd_port2_bank_tb;
  import pcd_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h000;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [4:0] mii_addr_i = 5'h00;
  logic [15:0] mii_wdata_i = 16'h0000;
  logic mii_we_i = 1'b0;
  logic mii_re_i = 1'b0;
  logic [1:0] egress_queue_mode_i = 2'h0;
  logic cdt_done_i = 1'b0;
  pcd_cdt_result_type cdt_result_i = '0;
  logic an_restart_ack_i = 1'b0;
  logic an_failed_i = 1'b0;
  logic an_speed_100_i = 1'b0;
  logic an_full_duplex_i = 1'b0;
  logic link_detect_i = 1'b0;
  logic fibre_mode_i = 1'b0;
  logic [15:0] reg_rdata_o, mii_rdata_o, er_m, cd_m, lc_m, q, d;
  logic [6:0] egress_limit_p2_o, egress_limit_p3_o;
  logic egress_limit_p2_en_o, egress_limit_p3_en_o, cdt_start_o, link_pass_o;
  logic an_restart_o, speed_100_o, full_duplex_o;
  pcd_line_ctrl_type line_ctrl_o;
  pcd_cdt_result_type r;
  int errors = 0;
  int n_compared = 0;
  int i;
  pcd_port2_bank dut_u (.mclk_i, .srst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .mii_addr_i, .mii_wdata_i, .mii_we_i, .mii_re_i, .mii_rdata_o,
    .egress_queue_mode_i, .egress_limit_p2_o, .egress_limit_p3_o, .egress_limit_p2_en_o,
    .egress_limit_p3_en_o, .cdt_start_o, .cdt_done_i, .cdt_result_i, .an_restart_ack_i,
    .an_failed_i, .an_speed_100_i, .an_full_duplex_i, .link_detect_i, .fibre_mode_i,
    .link_pass_o, .an_restart_o, .speed_100_o, .full_duplex_o, .line_ctrl_o);
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input bit m, input bit w, input logic [11:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    if (m) begin
      mii_addr_i <= a[4:0];
      mii_wdata_i <= v;
      mii_we_i <= w;
      mii_re_i <= !w;
    end else begin
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_we_i <= w;
      reg_re_i <= !w;
    end
    @(posedge mclk_i);
    {mii_we_i, mii_re_i, reg_we_i, reg_re_i} <= 4'h0;
    #1;
    q = m ? mii_rdata_o : reg_rdata_o;
  endtask
  // Model of the switch view.
  task automatic sw(input logic [11:0] a, input logic [15:0] v);
    bus(0, 1, a, v);
    if (a == OFS_EGRESS_RATE) er_m = v;
    if (a == OFS_CABLE_DIAG) cd_m = (cd_m & 16'hf1ff) | (v & 16'h1e00);
    if (a == OFS_LINE_CTRL) lc_m = (lc_m & 16'h2000) | (v & 16'hfffc);
  endtask
  task automatic rc(input bit m, input logic [11:0] a, input logic [15:0] k, e);
    bus(m, 0, a, 16'h0000);
    chk(q & k, e & k);
  endtask
  task automatic pulse(input bit ack);
    @(posedge mclk_i);
    an_restart_ack_i <= ack;
    cdt_done_i <= !ack;
    cdt_result_i <= r;
    @(posedge mclk_i);
    {an_restart_ack_i, cdt_done_i} <= 2'h0;
  endtask
  task automatic outs();
    pcd_line_ctrl_type x;
    x = {lc_m[14], lc_m[11], fibre_mode_i & !lc_m[12], !lc_m[10], lc_m[10] & lc_m[9],
      lc_m[8], cd_m[9], cd_m[11], lc_m[7:2]};
    chk(16'(line_ctrl_o[13:6]), 16'(x[13:6]));
    chk(16'(line_ctrl_o[5:0]), 16'(x[5:0]));
    chk(16'(egress_limit_p3_o), 16'(er_m[14:8]));
    chk(16'(egress_limit_p2_o), 16'(er_m[6:0]));
    chk(16'(egress_limit_p3_en_o),
      16'(egress_queue_mode_i == QUEUES_FOUR && er_m[14:8] != 7'h00));
    chk(16'(egress_limit_p2_en_o),
      16'(egress_queue_mode_i == QUEUES_FOUR && er_m[6:0] != 7'h00));
    chk(16'(link_pass_o), 16'(cd_m[11] | link_detect_i));
    chk(16'(speed_100_o), 16'(lc_m[7] ? an_speed_100_i : lc_m[6]));
    chk(16'(full_duplex_o), 16'(lc_m[7] ? an_full_duplex_i & !an_failed_i : lc_m[5]));
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(87176));
    r = '0;
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    er_m = 16'h0000;
    cd_m = 16'h0400;
    lc_m = 16'h00fc;
    rc(0, OFS_EGRESS_RATE, 16'hffff, er_m);
    rc(0, OFS_CABLE_DIAG, 16'hffff, cd_m);
    rc(0, OFS_LINE_CTRL, 16'hffff, lc_m);
    rc(0, 12'h098, 16'hffff, 16'h0000);
    outs();
    $display("test reset done");
    for (i = 0; i < 24; i++) begin
      @(posedge mclk_i);
      egress_queue_mode_i <= 2'($urandom);
      {an_failed_i, an_speed_100_i, an_full_duplex_i, link_detect_i, fibre_mode_i} <= 5'($urandom);
      sw(OFS_EGRESS_RATE, 16'($urandom));
      sw(OFS_CABLE_DIAG, 16'($urandom) & 16'hefff);
      sw(OFS_LINE_CTRL, 16'($urandom) & 16'hdfff);
      rc(0, OFS_EGRESS_RATE, 16'hffff, er_m);
      rc(0, OFS_CABLE_DIAG, 16'hffff, cd_m);
      rc(0, OFS_LINE_CTRL, 16'hffff, lc_m);
      rc(1, {7'h0, MII_BASIC_CTRL}, 16'h7b1e, {1'b0, lc_m[8], lc_m[6], lc_m[7], lc_m[11], 1'b0,
        lc_m[13], lc_m[5], 3'h0, lc_m[9], lc_m[10], lc_m[12], lc_m[14], 1'b0});
      rc(1, {7'h0, MII_ADVERT}, 16'h0580, {5'h0, lc_m[4], 1'b0, lc_m[3:2], 7'h0});
      rc(1, {7'h0, MII_SPECIAL_CTRL}, 16'h000a, {12'h0, cd_m[11], 1'b0, cd_m[9], 1'b0});
      outs();
      d = 16'($urandom) & 16'hfdff;
      bus(1, 1, {7'h0, MII_BASIC_CTRL}, d);
      {lc_m[14], lc_m[12:5]} = {d[1], d[2], d[11], d[3], d[4], d[14], d[12], d[13], d[8]};
      bus(1, 1, {7'h0, MII_ADVERT}, d);
      lc_m[4:2] = {d[10], d[8], d[7]};
      bus(1, 1, {7'h0, MII_SPECIAL_CTRL}, d);
      {cd_m[11], cd_m[9]} = {d[3], d[1]};
      rc(0, OFS_LINE_CTRL, 16'hffff, lc_m);
      rc(0, OFS_CABLE_DIAG, 16'hffff, cd_m);
    end
    $display("test random access done");
    for (i = 0; i < 4; i++) begin
      if (i[0]) begin
        bus(1, 1, {7'h0, MII_CABLE_DIAG}, 16'h8000);
        cd_m[12] = 1'b1;
      end else begin
        sw(OFS_CABLE_DIAG, cd_m | 16'h1000);
      end
      chk(16'(cdt_start_o), 16'h0001);
      sw(OFS_CABLE_DIAG, cd_m);
      chk(16'(cdt_start_o), 16'h0000);
      rc(0, OFS_CABLE_DIAG, 16'hffff, cd_m);
      r = pcd_cdt_result_type'(12'($urandom));
      r.outcome = 2'(i);
      pulse(1'b0);
      cd_m = {r.near_short, r.outcome, 1'b0, cd_m[11:9], r.distance};
      rc(0, OFS_CABLE_DIAG, 16'hffff, cd_m);
      rc(1, {7'h0, MII_CABLE_DIAG}, 16'hf1ff,
        {cd_m[12], cd_m[14:13], cd_m[15], 3'h0, cd_m[8:0]});
    end
    $display("test cable diagnostic done");
    sw(OFS_LINE_CTRL, lc_m | 16'h2000);
    chk(16'(an_restart_o), 16'h0001);
    rc(0, OFS_LINE_CTRL, 16'hffff, lc_m);
    pulse(1'b1);
    lc_m[13] = 1'b0;
    rc(0, OFS_LINE_CTRL, 16'hffff, lc_m);
    outs();
    bus(1, 1, {7'h0, MII_BASIC_CTRL}, 16'h0200);
    {lc_m[14:13], lc_m[12:5]} = 10'h100;
    chk(16'(an_restart_o), 16'h0001);
    rc(0, OFS_LINE_CTRL, 16'hffff, lc_m);
    pulse(1'b1);
    lc_m[13] = 1'b0;
    outs();
    $display("test negotiation restart done");
    @(posedge mclk_i);
    ce_i <= 1'b0;
    bus(0, 1, OFS_EGRESS_RATE, ~er_m);
    bus(0, 1, OFS_LINE_CTRL, ~lc_m);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rc(0, OFS_EGRESS_RATE, 16'hffff, er_m);
    rc(0, OFS_LINE_CTRL, 16'hffff, lc_m);
    outs();
    $display("test clock enable done");
    wrap_up();
  end
endmodule // pcd_port2_bank_tb

// *** verilog/pcd_pkg.sv ***
// Package with offsets, field positions, reset values and carrier types of the port 2 bank.
package pcd_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MII_ADDR_W = 5;
  localparam logic [11:0] OFS_EGRESS_RATE = 12'h092;
  localparam logic [11:0] OFS_CABLE_DIAG = 12'h094;
  localparam logic [11:0] OFS_LINE_CTRL = 12'h096;
  localparam logic [4:0] MII_BASIC_CTRL = 5'h00;
  localparam logic [4:0] MII_ADVERT = 5'h04;
  localparam logic [4:0] MII_CABLE_DIAG = 5'h1d;
  localparam logic [4:0] MII_SPECIAL_CTRL = 5'h1f;
  localparam int unsigned RATE_W = 7;
  localparam int unsigned FAULT_W = 9;
  // Egress rate register fields.
  localparam int unsigned ER_RSV_HI = 15;
  localparam int unsigned ER_PRIO3_LSB = 8;
  localparam int unsigned ER_RSV_LO = 7;
  localparam int unsigned ER_PRIO2_LSB = 0;
  localparam logic [6:0] ER_RATE_RST = 7'h00;
  // Cable diagnostic register fields.
  localparam int unsigned CD_SHORT = 15;
  localparam int unsigned CD_RES_LSB = 13;
  localparam int unsigned CD_TEST_EN = 12;
  localparam int unsigned CD_FORCE_LINK = 11;
  localparam int unsigned CD_RSV = 10;
  localparam int unsigned CD_REMOTE_LB = 9;
  localparam int unsigned CD_COUNT_LSB = 0;
  localparam logic CD_RSV_RST = 1'b1;
  // Port line control register fields.
  localparam int unsigned LC_RSV = 15;
  localparam int unsigned LC_TX_DIS = 14;
  localparam int unsigned LC_AN_RESTART = 13;
  localparam int unsigned LC_FEF_DIS = 12;
  localparam int unsigned LC_PWR_DN = 11;
  localparam int unsigned LC_MDIX_DIS = 10;
  localparam int unsigned LC_FORCE_MDIX = 9;
  localparam int unsigned LC_FAR_LB = 8;
  localparam int unsigned LC_AN_EN = 7;
  localparam int unsigned LC_SPEED = 6;
  localparam int unsigned LC_DUPLEX = 5;
  localparam int unsigned LC_ADV_PAUSE = 4;
  localparam int unsigned LC_ADV_100FD = 3;
  localparam int unsigned LC_ADV_100HD = 2;
  localparam logic LC_AN_EN_RST = 1'b1;
  localparam logic LC_SPEED_RST = 1'b1;
  localparam logic LC_DUPLEX_RST = 1'b1;
  localparam logic LC_ADV_RST = 1'b1;
  // PHY management basic control fields.
  localparam int unsigned BC_FAR_LB = 14;
  localparam int unsigned BC_SPEED = 13;
  localparam int unsigned BC_AN_EN = 12;
  localparam int unsigned BC_PWR_DN = 11;
  localparam int unsigned BC_AN_RESTART = 9;
  localparam int unsigned BC_DUPLEX = 8;
  localparam int unsigned BC_FORCE_MDIX = 4;
  localparam int unsigned BC_MDIX_DIS = 3;
  localparam int unsigned BC_FEF_DIS = 2;
  localparam int unsigned BC_TX_DIS = 1;
  // PHY management advertisement fields.
  localparam int unsigned AD_PAUSE = 10;
  localparam int unsigned AD_100FD = 8;
  localparam int unsigned AD_100HD = 7;
  // PHY management special control fields.
  localparam int unsigned SC_FORCE_LINK = 3;
  localparam int unsigned SC_REMOTE_LB = 1;
  // PHY management cable diagnostic fields.
  localparam int unsigned MD_TEST_EN = 15;
  localparam int unsigned MD_RES_LSB = 13;
  localparam int unsigned MD_SHORT = 12;
  localparam int unsigned MD_COUNT_LSB = 0;
  // Cable test outcome codes.
  localparam logic [1:0] CDT_NORMAL = 2'h0;
  localparam logic [1:0] CDT_OPEN = 2'h1;
  localparam logic [1:0] CDT_SHORT = 2'h2;
  localparam logic [1:0] CDT_FAILED = 2'h3;
  // Egress queue configuration codes.
  localparam logic [1:0] QUEUES_ONE = 2'h0;
  localparam logic [1:0] QUEUES_TWO = 2'h1;
  localparam logic [1:0] QUEUES_FOUR = 2'h2;

  typedef struct packed {
    logic near_short;
    logic [1:0] outcome;
    logic [8:0] distance;
  } pcd_cdt_result_type;

  typedef struct packed {
    logic tx_disable;
    logic power_down;
    logic fef_detect_en;
    logic auto_mdix_en;
    logic force_mdix;
    logic far_loopback;
    logic remote_loopback;
    logic force_link;
    logic an_enable;
    logic speed_100;
    logic full_duplex;
    logic adv_pause;
    logic adv_100fd;
    logic adv_100hd;
  } pcd_line_ctrl_type;
endpackage

// *** verilog/pcd_port2_bank.sv ***
// Port 2 rate, cable diagnostic and line control register bank.
`timescale 1ns/1ps
module pcd_port2_bank (
  // Clock, reset and enable.
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Switch register port.
  input wire logic [pcd_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pcd_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [pcd_pkg::DATA_W-1:0] reg_rdata_o,
  // PHY management register port.
  input wire logic [pcd_pkg::MII_ADDR_W-1:0] mii_addr_i,
  input wire logic [pcd_pkg::DATA_W-1:0] mii_wdata_i,
  input wire logic mii_we_i,
  input wire logic mii_re_i,
  output logic [pcd_pkg::DATA_W-1:0] mii_rdata_o,
  // Egress shaper interface.
  input wire logic [1:0] egress_queue_mode_i,
  output logic [pcd_pkg::RATE_W-1:0] egress_limit_p2_o,
  output logic [pcd_pkg::RATE_W-1:0] egress_limit_p3_o,
  output logic egress_limit_p2_en_o,
  output logic egress_limit_p3_en_o,
  // Cable tester interface.
  output logic cdt_start_o,
  input wire logic cdt_done_i,
  input wire pcd_pkg::pcd_cdt_result_type cdt_result_i,
  // Negotiation and link interface.
  input wire logic an_restart_ack_i,
  input wire logic an_failed_i,
  input wire logic an_speed_100_i,
  input wire logic an_full_duplex_i,
  input wire logic link_detect_i,
  input wire logic fibre_mode_i,
  output logic link_pass_o,
  output logic an_restart_o,
  output logic speed_100_o,
  output logic full_duplex_o,
  output pcd_pkg::pcd_line_ctrl_type line_ctrl_o
);
  import pcd_pkg::*;

  logic [RATE_W-1:0] rate_p3_q;
  logic [RATE_W-1:0] rate_p2_q;
  logic er_rsv_hi_q;
  logic er_rsv_lo_q;
  logic near_short_q;
  logic [1:0] outcome_q;
  logic test_en_q;
  logic force_link_q;
  logic cd_rsv_q;
  logic remote_lb_q;
  logic [FAULT_W-1:0] fault_distance_count_q;
  logic lc_rsv_q;
  logic tx_dis_q;
  logic an_restart_q;
  logic fef_dis_q;
  logic pwr_dn_q;
  logic mdix_dis_q;
  logic force_mdix_q;
  logic far_lb_q;
  logic an_en_q;
  logic speed_q;
  logic duplex_q;
  logic adv_pause_q;
  logic adv_100fd_q;
  logic adv_100hd_q;
  logic cdt_start_q;
  logic an_restart_pulse_q;
  logic [DATA_W-1:0] reg_rdata_q;
  logic [DATA_W-1:0] mii_rdata_q;
  logic sw_er, sw_cd, sw_lc, mi_bc, mi_ad, mi_sc, mi_cd;
  logic start_req;
  logic restart_req;
  logic [DATA_W-1:0] er_view, cd_view, lc_view, bc_view, ad_view, sc_view, md_view;

  // Write decode for both paths.
  always_comb begin
    sw_er = reg_we_i && (reg_addr_i == OFS_EGRESS_RATE);
    sw_cd = reg_we_i && (reg_addr_i == OFS_CABLE_DIAG);
    sw_lc = reg_we_i && (reg_addr_i == OFS_LINE_CTRL);
    mi_bc = mii_we_i && (mii_addr_i == MII_BASIC_CTRL);
    mi_ad = mii_we_i && (mii_addr_i == MII_ADVERT);
    mi_sc = mii_we_i && (mii_addr_i == MII_SPECIAL_CTRL);
    mi_cd = mii_we_i && (mii_addr_i == MII_CABLE_DIAG);
  end

  assign start_req = (sw_cd && reg_wdata_i[CD_TEST_EN]) || (mi_cd && mii_wdata_i[MD_TEST_EN]);
  assign restart_req = (sw_lc && reg_wdata_i[LC_AN_RESTART])
                       || (mi_bc && mii_wdata_i[BC_AN_RESTART]);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rate_p3_q <= ER_RATE_RST;
      rate_p2_q <= ER_RATE_RST;
      er_rsv_hi_q <= 1'b0;
      er_rsv_lo_q <= 1'b0;
    end else if (ce_i && sw_er) begin
      rate_p3_q <= reg_wdata_i[ER_PRIO3_LSB +: RATE_W];
      rate_p2_q <= reg_wdata_i[ER_PRIO2_LSB +: RATE_W];
      er_rsv_hi_q <= reg_wdata_i[ER_RSV_HI];
      er_rsv_lo_q <= reg_wdata_i[ER_RSV_LO];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      test_en_q <= 1'b0;
      cdt_start_q <= 1'b0;
    end else if (ce_i) begin
      cdt_start_q <= start_req && !test_en_q;
      if (start_req) begin
        test_en_q <= 1'b1;
      end else if (cdt_done_i) begin
        test_en_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      near_short_q <= 1'b0;
      outcome_q <= CDT_NORMAL;
      fault_distance_count_q <= '0;
    end else if (ce_i && cdt_done_i && test_en_q) begin
      near_short_q <= cdt_result_i.near_short;
      outcome_q <= cdt_result_i.outcome;
      fault_distance_count_q <= cdt_result_i.distance;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      force_link_q <= 1'b0;
      remote_lb_q <= 1'b0;
      cd_rsv_q <= CD_RSV_RST;
    end else if (ce_i) begin
      if (sw_cd) begin
        force_link_q <= reg_wdata_i[CD_FORCE_LINK];
        remote_lb_q <= reg_wdata_i[CD_REMOTE_LB];
        cd_rsv_q <= reg_wdata_i[CD_RSV];
      end else if (mi_sc) begin
        force_link_q <= mii_wdata_i[SC_FORCE_LINK];
        remote_lb_q <= mii_wdata_i[SC_REMOTE_LB];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      an_restart_q <= 1'b0;
      an_restart_pulse_q <= 1'b0;
    end else if (ce_i) begin
      an_restart_pulse_q <= restart_req && !an_restart_q;
      if (restart_req) begin
        an_restart_q <= 1'b1;
      end else if (an_restart_ack_i) begin
        an_restart_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lc_rsv_q <= 1'b0;
      tx_dis_q <= 1'b0;
      fef_dis_q <= 1'b0;
      pwr_dn_q <= 1'b0;
      mdix_dis_q <= 1'b0;
      force_mdix_q <= 1'b0;
      far_lb_q <= 1'b0;
      an_en_q <= LC_AN_EN_RST;
      speed_q <= LC_SPEED_RST;
      duplex_q <= LC_DUPLEX_RST;
    end else if (ce_i) begin
      if (sw_lc) begin
        lc_rsv_q <= reg_wdata_i[LC_RSV];
        tx_dis_q <= reg_wdata_i[LC_TX_DIS];
        fef_dis_q <= reg_wdata_i[LC_FEF_DIS];
        pwr_dn_q <= reg_wdata_i[LC_PWR_DN];
        mdix_dis_q <= reg_wdata_i[LC_MDIX_DIS];
        force_mdix_q <= reg_wdata_i[LC_FORCE_MDIX];
        far_lb_q <= reg_wdata_i[LC_FAR_LB];
        an_en_q <= reg_wdata_i[LC_AN_EN];
        speed_q <= reg_wdata_i[LC_SPEED];
        duplex_q <= reg_wdata_i[LC_DUPLEX];
      end else if (mi_bc) begin
        tx_dis_q <= mii_wdata_i[BC_TX_DIS];
        fef_dis_q <= mii_wdata_i[BC_FEF_DIS];
        pwr_dn_q <= mii_wdata_i[BC_PWR_DN];
        mdix_dis_q <= mii_wdata_i[BC_MDIX_DIS];
        force_mdix_q <= mii_wdata_i[BC_FORCE_MDIX];
        far_lb_q <= mii_wdata_i[BC_FAR_LB];
        an_en_q <= mii_wdata_i[BC_AN_EN];
        speed_q <= mii_wdata_i[BC_SPEED];
        duplex_q <= mii_wdata_i[BC_DUPLEX];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      adv_pause_q <= LC_ADV_RST;
      adv_100fd_q <= LC_ADV_RST;
      adv_100hd_q <= LC_ADV_RST;
    end else if (ce_i) begin
      if (sw_lc) begin
        adv_pause_q <= reg_wdata_i[LC_ADV_PAUSE];
        adv_100fd_q <= reg_wdata_i[LC_ADV_100FD];
        adv_100hd_q <= reg_wdata_i[LC_ADV_100HD];
      end else if (mi_ad) begin
        adv_pause_q <= mii_wdata_i[AD_PAUSE];
        adv_100fd_q <= mii_wdata_i[AD_100FD];
        adv_100hd_q <= mii_wdata_i[AD_100HD];
      end
    end
  end

  // Register views for both read paths.
  always_comb begin
    er_view = '0;
    er_view[ER_RSV_HI] = er_rsv_hi_q;
    er_view[ER_PRIO3_LSB +: RATE_W] = rate_p3_q;
    er_view[ER_RSV_LO] = er_rsv_lo_q;
    er_view[ER_PRIO2_LSB +: RATE_W] = rate_p2_q;
    cd_view = '0;
    cd_view[CD_SHORT] = near_short_q;
    cd_view[CD_RES_LSB +: 2] = outcome_q;
    cd_view[CD_TEST_EN] = test_en_q;
    cd_view[CD_FORCE_LINK] = force_link_q;
    cd_view[CD_RSV] = cd_rsv_q;
    cd_view[CD_REMOTE_LB] = remote_lb_q;
    cd_view[CD_COUNT_LSB +: FAULT_W] = fault_distance_count_q;
    lc_view = '0;
    lc_view[LC_RSV] = lc_rsv_q;
    lc_view[LC_TX_DIS] = tx_dis_q;
    lc_view[LC_AN_RESTART] = an_restart_q;
    lc_view[LC_FEF_DIS] = fef_dis_q;
    lc_view[LC_PWR_DN] = pwr_dn_q;
    lc_view[LC_MDIX_DIS] = mdix_dis_q;
    lc_view[LC_FORCE_MDIX] = force_mdix_q;
    lc_view[LC_FAR_LB] = far_lb_q;
    lc_view[LC_AN_EN] = an_en_q;
    lc_view[LC_SPEED] = speed_q;
    lc_view[LC_DUPLEX] = duplex_q;
    lc_view[LC_ADV_PAUSE] = adv_pause_q;
    lc_view[LC_ADV_100FD] = adv_100fd_q;
    lc_view[LC_ADV_100HD] = adv_100hd_q;
    bc_view = '0;
    bc_view[BC_FAR_LB] = far_lb_q;
    bc_view[BC_SPEED] = speed_q;
    bc_view[BC_AN_EN] = an_en_q;
    bc_view[BC_PWR_DN] = pwr_dn_q;
    bc_view[BC_AN_RESTART] = an_restart_q;
    bc_view[BC_DUPLEX] = duplex_q;
    bc_view[BC_FORCE_MDIX] = force_mdix_q;
    bc_view[BC_MDIX_DIS] = mdix_dis_q;
    bc_view[BC_FEF_DIS] = fef_dis_q;
    bc_view[BC_TX_DIS] = tx_dis_q;
    ad_view = '0;
    ad_view[AD_PAUSE] = adv_pause_q;
    ad_view[AD_100FD] = adv_100fd_q;
    ad_view[AD_100HD] = adv_100hd_q;
    sc_view = '0;
    sc_view[SC_FORCE_LINK] = force_link_q;
    sc_view[SC_REMOTE_LB] = remote_lb_q;
    md_view = '0;
    md_view[MD_TEST_EN] = test_en_q;
    md_view[MD_RES_LSB +: 2] = outcome_q;
    md_view[MD_SHORT] = near_short_q;
    md_view[MD_COUNT_LSB +: FAULT_W] = fault_distance_count_q;
  end

  // Switch port read data, zero for unmapped addresses.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_q <= '0;
    end else if (ce_i) begin
      if (!reg_re_i) begin
        reg_rdata_q <= '0;
      end else if (reg_addr_i == OFS_EGRESS_RATE) begin
        reg_rdata_q <= er_view;
      end else if (reg_addr_i == OFS_CABLE_DIAG) begin
        reg_rdata_q <= cd_view;
      end else if (reg_addr_i == OFS_LINE_CTRL) begin
        reg_rdata_q <= lc_view;
      end else begin
        reg_rdata_q <= '0;
      end
    end
  end

  // Management port read data, zero for unmapped addresses.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mii_rdata_q <= '0;
    end else if (ce_i) begin
      if (!mii_re_i) begin
        mii_rdata_q <= '0;
      end else if (mii_addr_i == MII_BASIC_CTRL) begin
        mii_rdata_q <= bc_view;
      end else if (mii_addr_i == MII_ADVERT) begin
        mii_rdata_q <= ad_view;
      end else if (mii_addr_i == MII_SPECIAL_CTRL) begin
        mii_rdata_q <= sc_view;
      end else if (mii_addr_i == MII_CABLE_DIAG) begin
        mii_rdata_q <= md_view;
      end else begin
        mii_rdata_q <= '0;
      end
    end
  end

  assign reg_rdata_o = reg_rdata_q;
  assign mii_rdata_o = mii_rdata_q;
  assign cdt_start_o = cdt_start_q;
  assign an_restart_o = an_restart_pulse_q;

  // Limits apply only with four queues.
  always_comb begin
    egress_limit_p2_o = rate_p2_q;
    egress_limit_p3_o = rate_p3_q;
    egress_limit_p2_en_o = (egress_queue_mode_i == QUEUES_FOUR) && (rate_p2_q != ER_RATE_RST);
    egress_limit_p3_en_o = (egress_queue_mode_i == QUEUES_FOUR) && (rate_p3_q != ER_RATE_RST);
  end

  assign link_pass_o = force_link_q || link_detect_i;
  assign speed_100_o = an_en_q ? an_speed_100_i : speed_q;
  assign full_duplex_o = an_en_q ? (an_full_duplex_i && !an_failed_i) : duplex_q;

  // Line control outputs.
  always_comb begin
    line_ctrl_o.tx_disable = tx_dis_q;
    line_ctrl_o.power_down = pwr_dn_q;
    line_ctrl_o.fef_detect_en = fibre_mode_i && !fef_dis_q;
    line_ctrl_o.auto_mdix_en = !mdix_dis_q;
    line_ctrl_o.force_mdix = mdix_dis_q && force_mdix_q;
    line_ctrl_o.far_loopback = far_lb_q;
    line_ctrl_o.remote_loopback = remote_lb_q;
    line_ctrl_o.force_link = force_link_q;
    line_ctrl_o.an_enable = an_en_q;
    line_ctrl_o.speed_100 = speed_q;
    line_ctrl_o.full_duplex = duplex_q;
    line_ctrl_o.adv_pause = adv_pause_q;
    line_ctrl_o.adv_100fd = adv_100fd_q;
    line_ctrl_o.adv_100hd = adv_100hd_q;
  end
endmodule // pcd_port2_bank
